// file: include/ccr_pkg.sv
// Package: register map, field layout and timing constants of the calendar clock block
package ccr_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned HALF_SEC_NS     = 500_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    // Half-second step counted in system clock cycles
    localparam int unsigned HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;

    // Register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] OFS_CFG     = 8'h00;
    localparam logic [7:0] OFS_TVAL    = 8'h04;
    localparam logic [7:0] OFS_ACFG    = 8'h08;
    localparam logic [7:0] OFS_AVAL    = 8'h0c;
    localparam logic [7:0] OFS_UNLOCK  = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_MASK    = 8'h18;

    // Field positions
    localparam int unsigned CFG_WREN_BIT   = 13;
    localparam int unsigned PTR_LSB        = 8;
    localparam int unsigned CFG_OUTSEL_BIT = 0;
    localparam int unsigned ACFG_EN_BIT    = 15;
    localparam int unsigned STS_ALARM_BIT  = 0;
    localparam int unsigned STS_SEC_BIT    = 1;

    // Two writes in a row open the write-enable window
    localparam logic [31:0] UNLOCK_KEY1 = 32'h0000_0055;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h0000_00aa;
    localparam int unsigned UNLOCK_WINDOW_CYCLES = 1;

    localparam logic [1:0] PTR_MINSEC = 2'h0;
    localparam logic [1:0] PTR_WDHR   = 2'h1;
    localparam logic [1:0] PTR_MONTH_AND_DAY_BCD_VALUE  = 2'h2;
    localparam logic [1:0] PTR_YEAR   = 2'h3;

    // Reset calendar value: Saturday 2000-01-01 00:00:00
    localparam logic [7:0] RST_YEAR  = 8'h00;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_DAY   = 8'h01;
    localparam logic [7:0] RST_WDAY  = 8'h06;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] wday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } ccr_time_t;

    typedef struct packed {
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] wday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } ccr_alarm_t;
endpackage

// file: rtl/ccr_calendar_clock.sv
// Calendar clock: BCD time keeping, pointer windows, write lock, alarm and tick output
module ccr_calendar_clock #(
    parameter int unsigned HALF_SEC_COUNT = ccr_pkg::HALF_SEC_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        master_clear_reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    output logic             clock_out_pin
);
    ccr_pkg::ccr_time_t  time_ff;
    ccr_pkg::ccr_alarm_t alarm_ff;
    logic [31:0] cnt_ff;
    logic        half_ff;
    logic        step_ff;
    logic        wren_ff;
    logic [1:0]  tptr_ff;
    logic [1:0]  aptr_ff;
    logic        outsel_ff;
    logic        alarm_en_ff;
    logic [1:0]  unlock_ff;
    logic [1:0]  unlock_win_ff;
    logic [1:0]  status_ff;
    logic [1:0]  mask_ff;
    logic [31:0] reg_rdata_ff;
    logic        pin_ff;
    logic        master_clear_reset_meta_ff;
    logic        master_clear_reset_sync_ff;
    logic        alarm_hit;
    logic        sec_tick;

    // Master clear only touches the bus side; counting never stops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_clear_reset_meta_ff <= 1'b0;
            master_clear_reset_sync_ff <= 1'b0;
        end else begin
            master_clear_reset_meta_ff <= !master_clear_reset_n;
            master_clear_reset_sync_ff <= master_clear_reset_meta_ff;
        end
    end

    logic wr_ok;
    logic rd_ok;
    assign wr_ok = reg_wr && !master_clear_reset_sync_ff;
    assign rd_ok = reg_rd && !master_clear_reset_sync_ff;

    // Half-second prescaler
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff  <= 32'h0;
            half_ff <= 1'b0;
            step_ff <= 1'b0;
        end else begin
            step_ff <= 1'b0;
            if (cnt_ff == 32'(HALF_SEC_COUNT - 1)) begin
                cnt_ff  <= 32'h0;
                half_ff <= !half_ff;
                step_ff <= half_ff;
            end else begin
                cnt_ff <= cnt_ff + 32'h1;
            end
        end
    end
    assign sec_tick = step_ff;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Last day of month; leap when BCD year divisible by 4 (2000 included)
    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00 && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8))
                              : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
        if (m == 8'h02) begin
            last_day = leap ? 8'h29 : 8'h28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            last_day = 8'h30;
        end else begin
            last_day = 8'h31;
        end
    endfunction

    // Write access to the time and alarm windows
    logic t_wr;
    logic a_wr;
    assign t_wr = wr_ok && reg_addr == ccr_pkg::OFS_TVAL;
    assign a_wr = wr_ok && reg_addr == ccr_pkg::OFS_AVAL;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            time_ff <= '{year: ccr_pkg::RST_YEAR, month: ccr_pkg::RST_MONTH, day: ccr_pkg::RST_DAY,
                         wday: ccr_pkg::RST_WDAY, hours: 8'h0, minutes: 8'h0, seconds: 8'h0};
        end else if (t_wr && wren_ff) begin
            case (tptr_ff)
                ccr_pkg::PTR_MINSEC: begin
                    time_ff.minutes <= reg_wdata[15:8];
                    time_ff.seconds <= reg_wdata[7:0];
                end
                ccr_pkg::PTR_WDHR: begin
                    time_ff.wday  <= {5'h0, reg_wdata[10:8]};
                    time_ff.hours <= {2'h0, reg_wdata[5:0]};
                end
                ccr_pkg::PTR_MONTH_AND_DAY_BCD_VALUE: begin
                    time_ff.month <= {3'h0, reg_wdata[12:8]};
                    time_ff.day   <= {2'h0, reg_wdata[5:0]};
                end
                default: begin
                    time_ff.year <= reg_wdata[7:0];
                end
            endcase
        end else if (sec_tick) begin
            if (time_ff.seconds != 8'h59) begin
                time_ff.seconds <= bcd_inc(time_ff.seconds);
            end else begin
                time_ff.seconds <= 8'h0;
                if (time_ff.minutes != 8'h59) begin
                    time_ff.minutes <= bcd_inc(time_ff.minutes);
                end else begin
                    time_ff.minutes <= 8'h0;
                    if (time_ff.hours != 8'h23) begin
                        time_ff.hours <= bcd_inc(time_ff.hours);
                    end else begin
                        time_ff.hours <= 8'h0;
                        time_ff.wday  <= (time_ff.wday == 8'h06) ? 8'h0 : time_ff.wday + 8'h1;
                        if (time_ff.day != last_day(time_ff.month, time_ff.year)) begin
                            time_ff.day <= bcd_inc(time_ff.day);
                        end else begin
                            time_ff.day <= 8'h01;
                            if (time_ff.month != 8'h12) begin
                                time_ff.month <= bcd_inc(time_ff.month);
                            end else begin
                                time_ff.month <= 8'h01;
                                time_ff.year  <= (time_ff.year == 8'h99) ? 8'h0 : bcd_inc(time_ff.year);
                            end
                        end
                    end
                end
            end
        end
    end

    // Alarm value registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_ff <= '0;
        end else if (a_wr) begin
            case (aptr_ff)
                ccr_pkg::PTR_MINSEC: begin
                    alarm_ff.minutes <= reg_wdata[15:8];
                    alarm_ff.seconds <= reg_wdata[7:0];
                end
                ccr_pkg::PTR_WDHR: begin
                    alarm_ff.wday  <= {5'h0, reg_wdata[10:8]};
                    alarm_ff.hours <= {2'h0, reg_wdata[5:0]};
                end
                ccr_pkg::PTR_MONTH_AND_DAY_BCD_VALUE: begin
                    alarm_ff.month <= {3'h0, reg_wdata[12:8]};
                    alarm_ff.day   <= {2'h0, reg_wdata[5:0]};
                end
                default: begin
                end
            endcase
        end
    end

    // Window accesses step pointers down, holding at zero
    logic cfg_wr;
    logic acfg_wr;
    logic t_rd;
    logic a_rd;
    assign cfg_wr  = wr_ok && reg_addr == ccr_pkg::OFS_CFG;
    assign acfg_wr = wr_ok && reg_addr == ccr_pkg::OFS_ACFG;
    assign t_rd    = rd_ok && reg_addr == ccr_pkg::OFS_TVAL;
    assign a_rd    = rd_ok && reg_addr == ccr_pkg::OFS_AVAL;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tptr_ff <= ccr_pkg::PTR_MINSEC;
            aptr_ff <= ccr_pkg::PTR_MINSEC;
        end else begin
            if (cfg_wr) begin
                tptr_ff <= reg_wdata[ccr_pkg::PTR_LSB +: 2];
            end else if ((t_wr || t_rd) && tptr_ff != ccr_pkg::PTR_MINSEC) begin
                tptr_ff <= tptr_ff - 2'h1;
            end
            if (acfg_wr) begin
                aptr_ff <= reg_wdata[ccr_pkg::PTR_LSB +: 2];
            end else if ((a_wr || a_rd) && aptr_ff != ccr_pkg::PTR_MINSEC) begin
                aptr_ff <= aptr_ff - 2'h1;
            end
        end
    end

    // Unlock sequence: key1 then key2, then a two-cycle window to set write enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_ff     <= 2'h0;
            unlock_win_ff <= 2'h0;
        end else begin
            if (wr_ok && reg_addr == ccr_pkg::OFS_UNLOCK) begin
                unlock_ff <= {unlock_ff[0] && reg_wdata == ccr_pkg::UNLOCK_KEY2,
                              reg_wdata == ccr_pkg::UNLOCK_KEY1};
            end else begin
                unlock_ff <= 2'h0;
            end
            unlock_win_ff <= (unlock_win_ff != 2'h0) ? unlock_win_ff - 2'h1
                           : (unlock_ff[1] ? 2'(ccr_pkg::UNLOCK_WINDOW_CYCLES) : 2'h0);
        end
    end

    logic win_open;
    assign win_open = unlock_ff[1] || unlock_win_ff != 2'h0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wren_ff     <= 1'b0;
            outsel_ff   <= 1'b0;
            alarm_en_ff <= 1'b0;
        end else begin
            if (cfg_wr) begin
                // Clearing always allowed; setting only inside the window
                wren_ff   <= reg_wdata[ccr_pkg::CFG_WREN_BIT] && (wren_ff || win_open);
                outsel_ff <= reg_wdata[ccr_pkg::CFG_OUTSEL_BIT];
            end
            if (acfg_wr) begin
                alarm_en_ff <= reg_wdata[ccr_pkg::ACFG_EN_BIT];
            end
        end
    end

    assign alarm_hit = alarm_en_ff && sec_tick
                    && alarm_ff == {time_ff.month, time_ff.day, time_ff.wday,
                                    time_ff.hours, time_ff.minutes, time_ff.seconds};

    // Sticky events; set wins over clear-on-read
    logic sts_rd;
    assign sts_rd = rd_ok && reg_addr == ccr_pkg::OFS_STATUS;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= 2'h0;
            mask_ff   <= 2'h0;
        end else begin
            status_ff <= (sts_rd ? 2'h0 : status_ff) | {sec_tick, alarm_hit};
            if (wr_ok && reg_addr == ccr_pkg::OFS_MASK) begin
                mask_ff <= reg_wdata[1:0];
            end
        end
    end
    assign irq = |(status_ff & mask_ff);

    // Pin: one-cycle seconds pulse or alarm pulse
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= outsel_ff ? sec_tick : alarm_hit;
        end
    end
    assign clock_out_pin = pin_ff;

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_ff <= 32'h0;
        end else if (rd_ok) begin
            if (reg_addr == ccr_pkg::OFS_CFG) begin
                reg_rdata_ff <= 32'({wren_ff, 3'h0, tptr_ff, 7'h0, outsel_ff});
            end else if (reg_addr == ccr_pkg::OFS_TVAL) begin
                case (tptr_ff)
                    ccr_pkg::PTR_MINSEC: reg_rdata_ff <= {16'h0, time_ff.minutes, time_ff.seconds};
                    ccr_pkg::PTR_WDHR:   reg_rdata_ff <= {16'h0, time_ff.wday, time_ff.hours};
                    ccr_pkg::PTR_MONTH_AND_DAY_BCD_VALUE:  reg_rdata_ff <= {16'h0, time_ff.month, time_ff.day};
                    default:             reg_rdata_ff <= {24'h0, time_ff.year};
                endcase
            end else if (reg_addr == ccr_pkg::OFS_ACFG) begin
                reg_rdata_ff <= 32'({alarm_en_ff, 5'h0, aptr_ff, 8'h0});
            end else if (reg_addr == ccr_pkg::OFS_AVAL) begin
                case (aptr_ff)
                    ccr_pkg::PTR_MINSEC: reg_rdata_ff <= {16'h0, alarm_ff.minutes, alarm_ff.seconds};
                    ccr_pkg::PTR_WDHR:   reg_rdata_ff <= {16'h0, alarm_ff.wday, alarm_ff.hours};
                    ccr_pkg::PTR_MONTH_AND_DAY_BCD_VALUE:  reg_rdata_ff <= {16'h0, alarm_ff.month, alarm_ff.day};
                    default:             reg_rdata_ff <= 32'h0;
                endcase
            end else if (reg_addr == ccr_pkg::OFS_STATUS) begin
                reg_rdata_ff <= {30'h0, status_ff};
            end else if (reg_addr == ccr_pkg::OFS_MASK) begin
                reg_rdata_ff <= {30'h0, mask_ff};
            end else begin
                reg_rdata_ff <= 32'h0;
            end
        end else begin
            reg_rdata_ff <= 32'h0;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    chk_ptr_hold_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (t_rd && tptr_ff == ccr_pkg::PTR_MINSEC && !cfg_wr) |=> tptr_ff == ccr_pkg::PTR_MINSEC)
        else $error("time pointer left zero");
    chk_tptr_dec: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ((t_wr || t_rd) && !cfg_wr && tptr_ff != 2'h0) |=> tptr_ff == $past(tptr_ff) - 2'h1)
        else $error("time pointer not decremented");
    chk_aptr_dec: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ((a_wr || a_rd) && !acfg_wr && aptr_ff != 2'h0) |=> aptr_ff == $past(aptr_ff) - 2'h1)
        else $error("alarm pointer not decremented");
    chk_locked_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (t_wr && !wren_ff && !sec_tick) |=> time_ff == $past(time_ff))
        else $error("locked time write changed time");
    chk_wren_window: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ($rose(wren_ff)) |-> $past(win_open))
        else $error("write enable set outside window");
    chk_year_bcd: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sec_tick && time_ff.year[3:0] <= 4'h9 |=> time_ff.year[3:0] <= 4'h9)
        else $error("year ones digit invalid");
    chk_sec_roll: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sec_tick && !t_wr && time_ff.seconds == 8'h59) |=> time_ff.seconds == 8'h00)
        else $error("seconds did not roll");
    sequence seq_pin_pulse;
        clock_out_pin ##1 !clock_out_pin;
    endsequence
    chk_pin_tick: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (outsel_ff && sec_tick && !cfg_wr) |=> seq_pin_pulse)
        else $error("tick pulse missing on pin");
endmodule // ccr_calendar_clock

// file: sim/tb.sv
// Self-checking bench for the calendar clock register block
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned HALF = 4;
    localparam logic [7:0] CFG  = ccr_pkg::OFS_CFG;
    localparam logic [7:0] TVAL = ccr_pkg::OFS_TVAL;
    localparam logic [7:0] ACFG = ccr_pkg::OFS_ACFG;
    localparam logic [7:0] AVAL = ccr_pkg::OFS_AVAL;

    logic        sys_clk              = 1'b0;
    logic        reset_n              = 1'b0;
    logic        master_clear_reset_n = 1'b1;
    logic [7:0]  reg_addr             = 8'h00;
    logic [31:0] reg_wdata            = 32'h0;
    logic        reg_wr               = 1'b0;
    logic        reg_rd               = 1'b0;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        clock_out_pin;
    int          miscompares          = 0;
    int          total_checks         = 0;
    int          cycles               = 0;
    int          n;
    logic [31:0] v;
    logic [7:0]  yr;
    logic [15:0] md;
    logic [15:0] ms;
    logic [7:0]  t_yr  [4] = '{8'h00, 8'h01, 8'h23, 8'h99};
    logic [15:0] t_md  [4] = '{16'h0228, 16'h0228, 16'h0430, 16'h1231};
    logic [7:0]  e_yr  [4] = '{8'h00, 8'h01, 8'h23, 8'h00};
    logic [15:0] e_md  [4] = '{16'h0229, 16'h0301, 16'h0501, 16'h0101};

    ccr_calendar_clock #(.HALF_SEC_COUNT(HALF)) DUT (
        .sys_clk              (sys_clk),
        .reset_n              (reset_n),
        .master_clear_reset_n (master_clear_reset_n),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .irq                  (irq),
        .clock_out_pin        (clock_out_pin)
    );

    always #25 sys_clk = ~sys_clk;

    // Ceiling well above the under one thousand cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Each call drives both strobes once, so back-to-back calls never double-assign
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask

    task automatic idle();
        acc(1'b0, 1'b0, reg_addr, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        acc(1'b0, 1'b1, a, 32'h0);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask

    task automatic unlock();
        wr(ccr_pkg::OFS_UNLOCK, ccr_pkg::UNLOCK_KEY1);
        wr(ccr_pkg::OFS_UNLOCK, ccr_pkg::UNLOCK_KEY2);
    endtask

    task automatic wait_pulse(output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            #1 c++;
        end while (clock_out_pin !== 1'b1 && c < 40);
    endtask

    function automatic logic [7:0] bcd(input int x);
        return {4'(x / 10), 4'(x % 10)};
    endfunction

    // Adds whole seconds to a minutes/seconds word, wrapping at the hour
    function automatic logic [15:0] ms_add(input logic [15:0] t, input int k);
        int s;
        s = (t[15:12] * 10 + t[11:8]) * 60 + t[7:4] * 10 + t[3:0] + k;
        s = s % 3600;
        return {bcd(s / 60), bcd(s % 60)};
    endfunction

    initial begin
        v = $urandom(60);
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Window walk from reset values, pointer sticks at zero
        wr(CFG, 32'h0000_0300);
        rd(TVAL, v); check(32'(v[15:0]), 32'h0000);
        rd(TVAL, v); check(32'(v[15:0]), 32'h0101);
        rd(TVAL, v); check(32'(v[15:0]), 32'h0600);
        rd(TVAL, v);
        rd(TVAL, v);
        rd(CFG, v); check(32'(v[9:8]), 32'h0);
        rd(8'h1c, v); check(v, 32'h0);
        $display("test window walk done");
        // Late set of write enable is refused, prompt set is taken
        unlock();
        repeat (3) idle();
        wr(CFG, 32'h0000_2000);
        rd(CFG, v); check(32'(v[13]), 32'h0);
        unlock();
        wr(CFG, 32'h0000_2300);
        rd(CFG, v); check(32'(v[13]), 32'h1);
        $display("test unlock window done");
        // Day, month and year rollover, leap years included
        for (int i = 0; i < 4; i++) begin
            unlock();
            wr(CFG, 32'h0000_2300);
            wr(TVAL, {24'h0, t_yr[i]});
            wr(TVAL, {16'h0, t_md[i]});
            wr(TVAL, 32'h0000_0623);
            wr(TVAL, 32'h0000_5959);
            rd(CFG, v); check(32'(v[9:8]), 32'h0);
            repeat (16) @(posedge sys_clk);
            unlock();
            wr(CFG, 32'h0000_2300);
            rd(TVAL, v); check(32'(v[15:0]), 32'(e_yr[i]));
            rd(TVAL, v); check(32'(v[15:0]), 32'(e_md[i]));
        end
        $display("test rollover done");
        // Random dates with junk in the unused bits
        for (int i = 0; i < 4; i++) begin
            yr = bcd(int'($urandom % 100));
            md = {bcd(int'($urandom % 12) + 1), bcd(int'($urandom % 28) + 1)};
            unlock();
            wr(CFG, 32'h0000_2300);
            wr(TVAL, {16'h0, 8'hff, yr});
            wr(TVAL, {16'h0, 3'b111, md[12:8], 2'b11, md[5:0]});
            unlock();
            wr(CFG, 32'h0000_2300);
            rd(TVAL, v); check(32'(v[15:0]), 32'(yr));
            rd(TVAL, v); check(32'(v[15:0]), 32'(md));
        end
        // Writes without write enable are dropped
        wr(CFG, 32'h0000_0300);
        wr(TVAL, 32'h0000_0042);
        wr(TVAL, 32'h0000_0112);
        wr(CFG, 32'h0000_0300);
        rd(TVAL, v); check(32'(v[15:0]), 32'(yr));
        rd(TVAL, v); check(32'(v[15:0]), 32'(md));
        $display("test date fields done");
        // Alarm window pointer
        wr(ACFG, 32'h0000_0200);
        wr(AVAL, 32'h0000_0315);
        wr(AVAL, 32'h0000_0412);
        wr(AVAL, 32'h0000_3045);
        wr(AVAL, 32'h0000_3046);
        rd(ACFG, v); check(32'(v[9:8]), 32'h0);
        wr(ACFG, 32'h0000_0200);
        rd(AVAL, v); check(32'(v[15:0]), 32'h0315);
        rd(AVAL, v); check(32'(v[15:0]), 32'h0412);
        rd(AVAL, v); check(32'(v[15:0]), 32'h3046);
        rd(ACFG, v); check(32'(v[9:8]), 32'h0);
        $display("test alarm window done");
        // Tick output, seconds and minutes carry
        wr(CFG, 32'h0000_0001);
        idle();
        wait_pulse(n);
        wait_pulse(n); check(32'(n), 32'(2 * HALF));
        rd(TVAL, v);
        ms = v[15:0];
        repeat (478) @(posedge sys_clk);
        rd(TVAL, v); check(32'(v[15:0]), 32'(ms_add(ms, 60)));
        ms = v[15:0];
        repeat (6) @(posedge sys_clk);
        rd(TVAL, v); check(32'(v[15:0]), 32'(ms_add(ms, 1)));
        $display("test tick done");
        // Interrupt raised by the seconds event, then masked
        wr(ccr_pkg::OFS_MASK, 32'h0000_0002);
        idle();
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(irq), 32'h1);
        rd(ccr_pkg::OFS_STATUS, v); check(32'(v[1]), 32'h1);
        wr(ccr_pkg::OFS_MASK, 32'h0);
        idle();
        #1 check(32'(irq), 32'h0);
        $display("test interrupt done");
        // Counting goes on through master clear; whole periods keep the count phase-free
        master_clear_reset_n <= 1'b0;
        n = 0;
        repeat (64) begin
            @(posedge sys_clk);
            #1 if (clock_out_pin === 1'b1) n++;
        end
        check(32'(n), 32'h8);
        master_clear_reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(CFG, 32'h0000_0301);
        rd(TVAL, v); check(32'(v[15:0]), 32'(yr));
        $display("test master clear done");
        // Time set equal to the stored alarm; pin switched to alarm
        wr(ACFG, 32'h0000_8000);
        unlock();
        wr(CFG, 32'h0000_2200);
        wr(TVAL, 32'h0000_0315);
        wr(TVAL, 32'h0000_0412);
        wr(TVAL, 32'h0000_3046);
        idle();
        wait_pulse(n); check(32'(clock_out_pin), 32'h1);
        rd(ccr_pkg::OFS_STATUS, v); check(32'(v[0]), 32'h1);
        wr(CFG, 32'h0000_0000);
        idle();
        $display("test alarm output done");
        finish_test();
    end
endmodule // tb
